/* File: src/bsd_top.sv */
// Selector top: AXI4-Lite register file, trigger and selection outputs.
// Assumes select lines and trigger synchronous to aclk.
`timescale 1ns/1ps
`include "bsd_regs.svh"

module bsd_top
   import bsd_pkg::*;
#(
   parameter int ADDR_W = `BSD_ADDR_W
)
(
   input  wire  logic              aclk,
   input  wire  logic              aresetn,
   input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire  logic              s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire  logic [31:0]       s_axi_wdata,
   input  wire  logic [3:0]        s_axi_wstrb,
   input  wire  logic              s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire  logic              s_axi_bready,
   input  wire  logic [ADDR_W-1:0] s_axi_araddr,
   input  wire  logic              s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire  logic              s_axi_rready,
   input  wire  bsd_code_t         select_in,
   input  wire  logic              decode_trigger,
   output bsd_onehot_t             selection_out,
   output logic                    selection_active
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   logic [ADDR_W-1:0] awaddr_ff,   nxt_awaddr;
   logic              aw_held_ff,  nxt_aw_held;
   logic [31:0]       wdata_ff,    nxt_wdata;
   logic [3:0]        wstrb_ff,    nxt_wstrb;
   logic              w_held_ff,   nxt_w_held;
   logic              bvalid_ff,   nxt_bvalid;
   logic [1:0]        bresp_ff,    nxt_bresp;
   logic              rvalid_ff,   nxt_rvalid;
   logic [31:0]       rdata_ff,    nxt_rdata;
   logic [1:0]        rresp_ff,    nxt_rresp;
   bsd_count_t        count_ff,    nxt_count;
   logic              sw_trig_ff,  nxt_sw_trig;
   bsd_code_t         code_ff,     nxt_code;
   bsd_onehot_t       sel_ff,      nxt_sel;
   logic              active_ff,   nxt_active;
   bsd_code_t         masked_code;
   bsd_onehot_t       onehot;
   logic              do_write;
   logic              trig;

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      logic ok;
      ok = (a == `BSD_CTRL_OFS) || (a == `BSD_STAT_OFS) || (a == `BSD_LINE_OFS)
           || (a[ADDR_W-1:5] == (ADDR_W-5)'(`BSD_SELW_BASE) && a[1:0] == 2'h0);
      return ok;
   endfunction : addr_mapped

   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == `BSD_CTRL_OFS) begin
         d[`BSD_CTRL_CNT_LSB +: `BSD_CNT_W] = count_ff;
         d[`BSD_CTRL_TRIG_BIT] = sw_trig_ff;
      end else if (a == `BSD_STAT_OFS) begin
         d[`BSD_LINES-1:0] = code_ff;
         d[`BSD_STAT_ACT_BIT] = active_ff;
      end else if (a == `BSD_LINE_OFS) begin
         d[`BSD_LINES-1:0] = select_in;
      end else if (addr_mapped(a)) begin
         d = sel_ff[a[4:2]*32 +: 32];
      end
      return d;
   endfunction : read_word

   // -------------------------------------------------------------------------
   // Write channels
   // -------------------------------------------------------------------------
   assign s_axi_awready = !aw_held_ff;
   assign s_axi_wready  = !w_held_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

   always_comb begin
      nxt_awaddr  = awaddr_ff;
      nxt_aw_held = aw_held_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_w_held  = w_held_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      if (s_axi_awvalid && !aw_held_ff) begin
         nxt_awaddr  = s_axi_awaddr;
         nxt_aw_held = 1'b1;
      end
      if (s_axi_wvalid && !w_held_ff) begin
         nxt_wdata  = s_axi_wdata;
         nxt_wstrb  = s_axi_wstrb;
         nxt_w_held = 1'b1;
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      if (do_write) begin
         nxt_aw_held = 1'b0;
         nxt_w_held  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = addr_mapped(awaddr_ff) ? `BSD_RESP_OKAY : `BSD_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_ff  <= '0;
         aw_held_ff <= 1'b0;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         w_held_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `BSD_RESP_OKAY;
      end else begin
         awaddr_ff  <= nxt_awaddr;
         aw_held_ff <= nxt_aw_held;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         w_held_ff  <= nxt_w_held;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
      end
   end

   // -------------------------------------------------------------------------
   // Read channels
   // -------------------------------------------------------------------------
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata  = rdata_ff;
      nxt_rresp  = rresp_ff;
      if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rdata  = read_word(s_axi_araddr);
         nxt_rresp  = addr_mapped(s_axi_araddr) ? `BSD_RESP_OKAY : `BSD_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= `BSD_RESP_OKAY;
      end else begin
         rvalid_ff <= nxt_rvalid;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rresp;
      end
   end

   // -------------------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------------------
   always_comb begin
      nxt_count   = count_ff;
      nxt_sw_trig = sw_trig_ff;
      if (do_write && awaddr_ff == `BSD_CTRL_OFS) begin
         if (wstrb_ff[0]) begin
            nxt_count = bsd_clamp_count(wdata_ff[`BSD_CTRL_CNT_LSB +: `BSD_CNT_W]);
         end
         if (wstrb_ff[1]) begin
            nxt_sw_trig = wdata_ff[`BSD_CTRL_TRIG_BIT];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_ff   <= `BSD_CNT_RST;
         sw_trig_ff <= 1'b0;
      end else begin
         count_ff   <= nxt_count;
         sw_trig_ff <= nxt_sw_trig;
      end
   end

   // -------------------------------------------------------------------------
   // Selector
   // -------------------------------------------------------------------------
   bsd_decoder i_bsd_decoder (
      .select_in       (select_in),
      .used_line_count (count_ff),
      .masked_code     (masked_code),
      .onehot          (onehot)
   );

   assign trig = decode_trigger || sw_trig_ff;

   always_comb begin
      nxt_code   = code_ff;
      nxt_sel    = '0;
      nxt_active = 1'b0;
      if (trig) begin
         nxt_code   = masked_code;
         nxt_sel    = onehot;
         nxt_active = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_ff   <= '0;
         sel_ff    <= '0;
         active_ff <= 1'b0;
      end else begin
         code_ff   <= nxt_code;
         sel_ff    <= nxt_sel;
         active_ff <= nxt_active;
      end
   end

   assign selection_out    = sel_ff;
   assign selection_active = active_ff;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   a_track_code: assert property (@(posedge aclk) disable iff (!aresetn)
      trig |=> (sel_ff[$past(masked_code)] && code_ff == $past(masked_code)))
      else $error("selection does not follow select lines");

   a_one_hot: assert property (@(posedge aclk) disable iff (!aresetn)
      active_ff |-> $onehot(sel_ff))
      else $error("selection not one-hot while active");

   a_idle_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      !trig |=> (sel_ff == '0 && !active_ff))
      else $error("selection active without trigger");

   a_reach_limit: assert property (@(posedge aclk) disable iff (!aresetn)
      active_ff |-> ((code_ff >> $past(count_ff)) == '0))
      else $error("selection beyond reachable range");

   a_count_range: assert property (@(posedge aclk) disable iff (!aresetn)
      (count_ff >= `BSD_CNT_MIN) && (count_ff <= `BSD_CNT_MAX))
      else $error("line count out of range");

   a_lsb_first: assert property (@(posedge aclk) disable iff (!aresetn)
      trig && select_in[0] |=> code_ff[0])
      else $error("first select line not least significant");

   a_held_code: assert property (@(posedge aclk) disable iff (!aresetn)
      trig && $past(trig) && $stable(select_in) && $stable(count_ff) |=> $stable(sel_ff))
      else $error("selection changed with steady code");

   a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
      else $error("write response dropped");

   a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_ff && !s_axi_rready |=> rvalid_ff && $stable(rdata_ff))
      else $error("read data dropped");

   a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> bvalid_ff)
      else $error("no write response after write");

   a_trig_active: assert property (@(posedge aclk) disable iff (!aresetn)
      trig |=> active_ff)
      else $error("trigger did not start decoding");

   a_idle_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !active_ff |-> (sel_ff == '0))
      else $error("selection set while idle");

   a_index_range: assert property (@(posedge aclk) disable iff (!aresetn)
      active_ff |-> ((sel_ff >> (9'h1 << $past(count_ff))) == '0))
      else $error("selection index beyond reachable outputs");

   a_rresp_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && !rvalid_ff && !addr_mapped(s_axi_araddr)
      |=> (rresp_ff == `BSD_RESP_SLVERR))
      else $error("unmapped read not refused");

   a_wresp_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && !addr_mapped(awaddr_ff) |=> (bresp_ff == `BSD_RESP_SLVERR))
      else $error("unmapped write not refused");

endmodule : bsd_top

/* File: src/bsd_regs.svh */
// Register map, field positions, reset values and limits of the selector.
// Assumes inclusion by the package and by the top module of the block.
`ifndef BSD_REGS_SVH
`define BSD_REGS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define BSD_LINES           8
`define BSD_OUTS            256
`define BSD_ADDR_W          8
`define BSD_CNT_W           4
`define BSD_WORDS           8

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define BSD_CTRL_OFS        8'h00
`define BSD_STAT_OFS        8'h04
`define BSD_LINE_OFS        8'h08
`define BSD_SELW_BASE       3'h1

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define BSD_CTRL_CNT_LSB    0
`define BSD_CTRL_TRIG_BIT   8
`define BSD_STAT_ACT_BIT    8
`define BSD_CNT_MIN         4'h1
`define BSD_CNT_MAX         4'h8
`define BSD_CNT_RST         4'h8
`define BSD_RESP_OKAY       2'h0
`define BSD_RESP_SLVERR     2'h2

`endif

/* File: src/bsd_pkg.sv */
// Types and shared decode helper of the selector.
// Assumes bsd_regs.svh on the include path.
`include "bsd_regs.svh"

package bsd_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef logic [`BSD_LINES-1:0] bsd_code_t;
   typedef logic [`BSD_CNT_W-1:0] bsd_count_t;
   typedef logic [`BSD_OUTS-1:0]  bsd_onehot_t;

   // -------------------------------------------------------------------------
   // Mask of the select lines taking part
   // -------------------------------------------------------------------------
   function automatic bsd_code_t bsd_line_mask(input bsd_count_t count);
      bsd_code_t m;
      m = '0;
      for (int i = 0; i < `BSD_LINES; i++) begin
         m[i] = (`BSD_CNT_W'(i) < count);
      end
      return m;
   endfunction : bsd_line_mask

   // Clamp of a written line count into its legal range
   function automatic bsd_count_t bsd_clamp_count(input bsd_count_t count);
      bsd_count_t c;
      c = count;
      if (count < `BSD_CNT_MIN) begin
         c = `BSD_CNT_MIN;
      end else if (count > `BSD_CNT_MAX) begin
         c = `BSD_CNT_MAX;
      end
      return c;
   endfunction : bsd_clamp_count

endpackage : bsd_pkg

/* File: src/bsd_decoder.sv */
// Binary to one-of-N decoder of the selector.
// Assumes a legal line count from the register file.
`timescale 1ns/1ps

module bsd_decoder
   import bsd_pkg::*;
(
   input  wire bsd_code_t   select_in,
   input  wire bsd_count_t  used_line_count,
   output bsd_code_t        masked_code,
   output bsd_onehot_t      onehot
);

   // -------------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------------
   always_comb begin
      masked_code = select_in & bsd_line_mask(used_line_count);
      onehot = '0;
      onehot[masked_code] = 1'b1;
   end

endmodule : bsd_decoder

/* File: tb/bsd_line_model.sv */
// Far-side model: digital input lines feeding the selector.
// Assumes the bench sets the wanted code and trigger levels after a rising edge.
`timescale 1ns/1ps

module bsd_line_model
   import bsd_pkg::*;
(
   input  wire bsd_code_t code_req,
   input  wire logic      trig_req,
   output bsd_code_t      select_in,
   output logic           decode_trigger
);
   // -------------------------------------------------------------------------
   // Level sources, held as long as the request stands
   // -------------------------------------------------------------------------
   assign select_in      = code_req;
   assign decode_trigger = trig_req;
endmodule : bsd_line_model

/* File: tb/test_bsd_top.sv */
// Self-checking bench of the selector top.
// Assumes bsd_pkg, bsd_regs.svh and bsd_line_model are compiled first.
`timescale 1ns/1ps
`include "bsd_regs.svh"

module test_bsd_top;
   import bsd_pkg::*;
   // -------------------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------------------
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig_req;
   logic awready, wready, bvalid, arready, rvalid, selection_active, decode_trigger;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   bsd_code_t code_req, select_in;
   bsd_onehot_t selection_out;
   logic [255:0] rq[$], bq[$], sq[$];
   int err_count, comparisons, cycles;
   logic [7:0] code, mask;

   bsd_line_model i_bsd_line_model (.code_req(code_req), .trig_req(trig_req),
      .select_in(select_in), .decode_trigger(decode_trigger));

   bsd_top i_bsd_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .select_in(select_in), .decode_trigger(decode_trigger),
      .selection_out(selection_out), .selection_active(selection_active));

   // -------------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------------
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(256'(r));
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'h3;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            break;
         end
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back(256'({r, d}));
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            break;
         end
      end
   endtask : axi_rd

   // Holds the trigger for n cycles with random codes, noting each selection
   task automatic burst(input int n, input logic [3:0] cnt);
      mask = 8'((9'h1 << cnt) - 9'h1);
      for (int k = 0; k < n; k++) begin
         @(posedge aclk);
         if (k % 2 == 0) begin
            code = 8'($urandom);
         end
         code_req <= code;
         trig_req <= 1'b1;
         sq.push_back(256'(1) << (code & mask));
      end
      @(posedge aclk);
      trig_req <= 1'b0;
      code_req <= ~code;
      repeat (2) @(posedge aclk);
      #1;
      check(256'(selection_out), 256'h0);
      check(256'(selection_active), 256'h0);
   endtask : burst

   // -------------------------------------------------------------------------
   // Result watcher
   // -------------------------------------------------------------------------
   always @(posedge aclk) begin
      if (aresetn === 1'b1) begin
         if (rvalid === 1'b1 && rready) check(256'({rresp, rdata}), rq.size() ? rq.pop_front() : 'x);
         if (bvalid === 1'b1 && bready) check(256'(bresp), bq.size() ? bq.pop_front() : 'x);
         if (selection_active === 1'b1) check(selection_out, sq.size() ? sq.pop_front() : 'x);
      end
   end

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, trig_req} = '0;
      {awaddr, araddr, wdata, wstrb, code_req} = '0;
      {err_count, comparisons, cycles} = '0;
      void'($urandom(32'h25CA));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`BSD_CTRL_OFS, 32'h8, `BSD_RESP_OKAY);
      axi_rd(8'h80, 32'h0, `BSD_RESP_SLVERR);
      axi_wr(8'hFC, 32'h3, `BSD_RESP_SLVERR);
      $display("test reset and map done");
      for (int c = 1; c <= 8; c++) begin
         axi_wr(`BSD_CTRL_OFS, 32'(c), `BSD_RESP_OKAY);
         burst(6, 4'(c));
         axi_rd(`BSD_STAT_OFS, 32'(code & mask), `BSD_RESP_OKAY);
         axi_rd(`BSD_LINE_OFS, {24'h0, ~code}, `BSD_RESP_OKAY);
      end
      $display("test line counts done");
      axi_wr(`BSD_CTRL_OFS, 32'h0, `BSD_RESP_OKAY);
      axi_rd(`BSD_CTRL_OFS, 32'h1, `BSD_RESP_OKAY);
      axi_wr(`BSD_CTRL_OFS, 32'hF, `BSD_RESP_OKAY);
      axi_rd(`BSD_CTRL_OFS, 32'h8, `BSD_RESP_OKAY);
      axi_rd(8'h3C, 32'h0, `BSD_RESP_OKAY);
      $display("test clamp done");
      code_req <= 8'hA5;
      repeat (10) sq.push_back(256'(1) << 8'hA5);
      axi_wr(`BSD_CTRL_OFS, 32'h108, `BSD_RESP_OKAY);
      axi_rd(8'h34, 32'h20, `BSD_RESP_OKAY);
      axi_rd(`BSD_STAT_OFS, 32'h1A5, `BSD_RESP_OKAY);
      axi_wr(`BSD_CTRL_OFS, 32'h8, `BSD_RESP_OKAY);
      repeat (2) @(posedge aclk);
      #1;
      check(256'(selection_active), 256'h0);
      $display("test software trigger done");
      repeat (4) @(posedge aclk);
      check(256'(rq.size() + bq.size() + sq.size()), 256'h0);
      final_report();
   end
endmodule : test_bsd_top
